// ==== logic/virqp_top.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - Enable per bit or by number writes
// - Enabled asserted source raises fast, or normal when its level is above the mask
// - Register access only in supervisor mode
// - Fast and normal raised independently; highest level wins among normal, highest number among fast
// - Equal level: highest source number wins
// - Sixteen levels, zero is lowest
// - Eight writable priority level registers
// - Mask register suppresses normal levels
module virqp_top (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [virqp_pkg::NSRC-1:0] src_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_sup_i,
	input wire logic [virqp_pkg::ADDRW-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_ack_o,
	output logic reg_err_o,
	output logic fast_req_o,
	output logic norm_req_o,
	output logic [virqp_pkg::IDXW-1:0] fast_src_o,
	output logic [virqp_pkg::IDXW-1:0] norm_src_o,
	output logic [virqp_pkg::LVLW-1:0] norm_lvl_o
);
	import virqp_pkg::*;

	// ==========================================================
	// Programmable state
	logic [NSRC-1:0] ena_q;
	logic [NSRC-1:0] ena_d;
	logic [NSRC-1:0] type_q;
	logic [NSRC-1:0] type_d;
	logic [LVLW-1:0] mask_q;
	logic [NPRIO_REG-1:0][31:0] prio_q;
	logic [31:0] reg_rdata_q;
	logic [31:0] reg_rdata_d;
	logic reg_ack_q;
	logic reg_err_q;
	logic fast_req_q;
	logic norm_req_q;
	logic [IDXW-1:0] fast_src_q;
	logic [IDXW-1:0] norm_src_q;
	logic [LVLW-1:0] norm_lvl_q;

	// ==========================================================
	// Access decode
	wire logic access = reg_wr_i | reg_rd_i;
	// Every index is mapped, so only the mode qualifies an access
	wire logic allowed = reg_sup_i;
	// User-mode accesses are dropped here, so they write and read no register; only ack and error respond
	wire logic wr_ok = reg_wr_i & allowed;
	wire logic rd_ok = reg_rd_i & allowed & ~reg_wr_i;
	wire logic is_prio = reg_addr_i[ADDRW-1];
	wire logic [2:0] prio_sel = reg_addr_i[2:0];
	wire logic wr_ena_lo = wr_ok & (reg_addr_i == REG_ENA_LO);
	wire logic wr_ena_hi = wr_ok & (reg_addr_i == REG_ENA_HI);
	wire logic wr_en_num = wr_ok & (reg_addr_i == REG_EN_NUM);
	wire logic wr_dis_num = wr_ok & (reg_addr_i == REG_DIS_NUM);
	wire logic wr_type_lo = wr_ok & (reg_addr_i == REG_TYPE_LO);
	wire logic wr_type_hi = wr_ok & (reg_addr_i == REG_TYPE_HI);
	wire logic wr_mask = wr_ok & (reg_addr_i == REG_MASK);
	wire logic wr_prio = wr_ok & is_prio;
	wire logic [IDXW-1:0] num = reg_wdata_i[IDXW-1:0];

	// ==========================================================
	// Enable next value: whole words or one source by number
	always_comb begin
		ena_d = ena_q;
		if (wr_ena_lo) begin
			ena_d[31:0] = reg_wdata_i;
		end
		if (wr_ena_hi) begin
			ena_d[63:32] = reg_wdata_i;
		end
		if (wr_en_num) begin
			ena_d[num] = 1'b1;
		end
		if (wr_dis_num) begin
			ena_d[num] = 1'b0;
		end
	end

	// Type next value: a set bit routes the source to the fast line
	always_comb begin
		type_d = type_q;
		if (wr_type_lo) begin
			type_d[31:0] = reg_wdata_i;
		end
		if (wr_type_hi) begin
			type_d[63:32] = reg_wdata_i;
		end
	end

	// Configuration registers
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ena_q <= ENA_RST;
			type_q <= TYPE_RST;
			mask_q <= MASK_RST;
		end else begin
			ena_q <= ena_d;
			type_q <= type_d;
			if (wr_mask) begin
				mask_q <= reg_wdata_i[LVLW-1:0];
			end
		end
	end

	// Eight level registers, eight 4-bit fields each
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			prio_q <= {NPRIO_REG{PRIO_RST}};
		end else if (wr_prio) begin
			prio_q[prio_sel] <= reg_wdata_i;
		end
	end

	// ==========================================================
	// Per-source gating
	virqp_arb_if arb_bus ();
	logic [NSRC-1:0] fast_pend;

	for (genvar i = 0; i < NSRC; i++) begin : g_src
		wire logic [LVLW-1:0] lvl = prio_q[i / FLD_PER_REG][(i % FLD_PER_REG)*LVLW +: LVLW];
		wire logic live = src_i[i] & ena_q[i];
		// Strictly above the mask: a mask of zero still blocks level zero
		wire logic above = lvl > mask_q;
		assign arb_bus.lvl[i*LVLW +: LVLW] = lvl;
		assign arb_bus.pend[i] = live & ~type_q[i] & above;
		assign fast_pend[i] = live & type_q[i];
	end

	virqp_arbiter u_arb (
		.bus(arb_bus.arb)
	);

	// ==========================================================
	// Fast winner: no levels among fast sources, highest number wins
	logic fast_vld;
	logic [IDXW-1:0] fast_idx;

	always_comb begin
		fast_vld = 1'b0;
		fast_idx = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (fast_pend[i]) begin
				fast_vld = 1'b1;
				fast_idx = IDXW'(i);
			end
		end
	end

	// Request outputs, one cycle behind the sources
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			fast_req_q <= 1'b0;
			norm_req_q <= 1'b0;
			fast_src_q <= '0;
			norm_src_q <= '0;
			norm_lvl_q <= '0;
		end else begin
			fast_req_q <= fast_vld;
			norm_req_q <= arb_bus.win_vld;
			fast_src_q <= fast_idx;
			norm_src_q <= arb_bus.win_idx;
			norm_lvl_q <= arb_bus.win_lvl;
		end
	end

	// ==========================================================
	// Read path
	wire logic [31:0] vector_word = {fast_vld, arb_bus.win_vld, 8'h00, fast_idx,
		4'h0, arb_bus.win_lvl, 2'h0, arb_bus.win_idx};

	// Number registers are write-only and read as zero
	always_comb begin
		reg_rdata_d = 32'h0;
		if (is_prio) begin
			reg_rdata_d = prio_q[prio_sel];
		end else begin
			unique case (reg_addr_i)
				REG_ENA_LO: reg_rdata_d = ena_q[31:0];
				REG_ENA_HI: reg_rdata_d = ena_q[63:32];
				REG_TYPE_LO: reg_rdata_d = type_q[31:0];
				REG_TYPE_HI: reg_rdata_d = type_q[63:32];
				REG_MASK: reg_rdata_d = {28'h0, mask_q};
				REG_VECTOR: reg_rdata_d = vector_word;
				default: reg_rdata_d = 32'h0;
			endcase
		end
	end

	// Answer one cycle after the access; refused accesses read zero
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			reg_rdata_q <= 32'h0;
			reg_ack_q <= 1'b0;
			reg_err_q <= 1'b0;
		end else begin
			reg_rdata_q <= rd_ok ? reg_rdata_d : 32'h0;
			reg_ack_q <= access;
			reg_err_q <= access & ~allowed;
		end
	end

	// ==========================================================
	// Outputs straight from flip-flops
	assign reg_rdata_o = reg_rdata_q;
	assign reg_ack_o = reg_ack_q;
	assign reg_err_o = reg_err_q;
	assign fast_req_o = fast_req_q;
	assign norm_req_o = norm_req_q;
	assign fast_src_o = fast_src_q;
	assign norm_src_o = norm_src_q;
	assign norm_lvl_o = norm_lvl_q;
endmodule

// ==== pkg/virqp_pkg.sv ====
package virqp_pkg;
	// ==========================================================
	// Source and level geometry
	localparam int NSRC = 64;
	localparam int IDXW = 6;
	localparam int LVLW = 4;
	localparam int NPRIO_REG = 8;
	localparam int FLD_PER_REG = 8;
	localparam int ADDRW = 4;

	// ==========================================================
	// Register word indices
	localparam logic [ADDRW-1:0] REG_ENA_LO = 4'h0;
	localparam logic [ADDRW-1:0] REG_ENA_HI = 4'h1;
	localparam logic [ADDRW-1:0] REG_EN_NUM = 4'h2;
	localparam logic [ADDRW-1:0] REG_DIS_NUM = 4'h3;
	localparam logic [ADDRW-1:0] REG_TYPE_LO = 4'h4;
	localparam logic [ADDRW-1:0] REG_TYPE_HI = 4'h5;
	localparam logic [ADDRW-1:0] REG_MASK = 4'h6;
	localparam logic [ADDRW-1:0] REG_VECTOR = 4'h7;
	localparam logic [ADDRW-1:0] REG_PRIO0 = 4'h8;

	// ==========================================================
	// Field positions in the vector status word
	localparam int VEC_NORM_SRC_LSB = 0;
	localparam int VEC_NORM_LVL_LSB = 8;
	localparam int VEC_FAST_SRC_LSB = 16;
	localparam int VEC_NORM_VLD_BIT = 30;
	localparam int VEC_FAST_VLD_BIT = 31;

	// ==========================================================
	// Values after reset
	localparam logic [NSRC-1:0] ENA_RST = 64'h0;
	localparam logic [NSRC-1:0] TYPE_RST = 64'h0;
	localparam logic [LVLW-1:0] MASK_RST = 4'h0;
	localparam logic [31:0] PRIO_RST = 32'h0;
endpackage

// ==== pkg/virqp_arb_if.sv ====
`timescale 1ns/100ps
// ==========================================================
// Carrier between the gating logic and the level arbiter
interface virqp_arb_if;
	import virqp_pkg::*;
	logic [NSRC-1:0] pend;
	logic [NSRC*LVLW-1:0] lvl;
	logic win_vld;
	logic [IDXW-1:0] win_idx;
	logic [LVLW-1:0] win_lvl;
	modport arb (input pend, input lvl, output win_vld, output win_idx, output win_lvl);
	modport ctl (output pend, output lvl, input win_vld, input win_idx, input win_lvl);
endinterface

// ==== logic/virqp_arbiter.sv ====
`timescale 1ns/100ps
// ==========================================================
// Normal-request arbiter: highest level, then highest number
module virqp_arbiter (
	virqp_arb_if.arb bus
);
	import virqp_pkg::*;

	// Ascending scan with >= lets a later, higher number win a tie
	always_comb begin
		bus.win_vld = 1'b0;
		bus.win_idx = '0;
		bus.win_lvl = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (bus.pend[i] && (!bus.win_vld || bus.lvl[i*LVLW +: LVLW] >= bus.win_lvl)) begin
				bus.win_vld = 1'b1;
				bus.win_idx = IDXW'(i);
				bus.win_lvl = bus.lvl[i*LVLW +: LVLW];
			end
		end
	end
endmodule

// ==== tb/virqp_assertions.sv ====
`timescale 1ns/100ps
// ==========================================================
// Port checker
module virqp_assertions (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [63:0] src_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_sup_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic reg_ack_o,
	input wire logic reg_err_o,
	input wire logic fast_req_o,
	input wire logic norm_req_o,
	input wire logic [5:0] fast_src_o,
	input wire logic [5:0] norm_src_o,
	input wire logic [3:0] norm_lvl_o
);
	logic [63:0] src_q;
	wire acc = reg_wr_i | reg_rd_i;
	// Source image lined up with the registered outputs
	always_ff @(posedge core_clk_i) src_q <= src_i;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	a_ack_pulse: assert property (acc |=> reg_ack_o) else $error("no ack");
	a_ack_cause: assert property (!acc |=> !reg_ack_o && !reg_err_o)
		else $error("stray ack");
	a_user_refused: assert property (acc && !reg_sup_i |=> reg_err_o && reg_rdata_o == 32'h0)
		else $error("user access not refused");
	a_sup_ok: assert property (acc && reg_sup_i |=> !reg_err_o) else $error("sup refused");
	a_fast_cause: assert property (fast_req_o |-> src_q[fast_src_o]) else $error("fast");
	a_norm_cause: assert property (norm_req_o |-> src_q[norm_src_o] && norm_lvl_o != 4'h0)
		else $error("normal without cause");
	a_fast_idle: assert property (!fast_req_o |-> fast_src_o == 6'h0) else $error("fast idx");
	a_norm_idle: assert property (!norm_req_o |-> {norm_src_o, norm_lvl_o} == 10'h0)
		else $error("normal idx");
	a_src_drop: assert property (src_i == 64'h0 |=> !fast_req_o && !norm_req_o)
		else $error("request without source");
endmodule
bind virqp_top virqp_assertions u_chk (.*);

// ==== tb/virqp_core_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// Core side: fast requests only, so it just counts fast entries
module virqp_core_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic fast_req_i,
	output logic [7:0] n_fast_o
);
	logic fast_q;
	// Rising request counter
	always_ff @(posedge core_clk_i) begin
		fast_q <= fast_req_i;
		if (rst_i) n_fast_o <= 8'h0;
		else if (fast_req_i && !fast_q) n_fast_o <= n_fast_o + 8'h1;
	end
endmodule

// ==== tb/virqp_top_tb.sv ====
`timescale 1ns/100ps
module virqp_top_tb;
	import virqp_pkg::*;
	logic core_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, reg_sup_i = 0;
	logic [63:0] src_i = 64'h0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
	logic reg_ack_o, reg_err_o, fast_req_o, norm_req_o;
	logic [5:0] fast_src_o, norm_src_o;
	logic [3:0] norm_lvl_o;
	logic [7:0] n_fast;
	int n_errors = 0, num_checks = 0, cyc = 0;
	always #4 core_clk_i = ~core_clk_i;
	virqp_top DUT (.*);
	virqp_core_model u_core (.core_clk_i(core_clk_i), .rst_i(rst_i), .fast_req_i(fast_req_o),
		.n_fast_o(n_fast));
	// ==========================================================
	// Compare and access tasks
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Outputs lag a register write by two edges
	task automatic chk_irq(input logic f, input logic [5:0] fs, input logic n,
		input logic [5:0] ns, input logic [3:0] nl);
		repeat (2) @(posedge core_clk_i);
		#1;
		cmp(32'({fast_req_o, fast_src_o, norm_req_o, norm_src_o, norm_lvl_o}),
			32'({f, fs, n, ns, nl}));
	endtask
	// Strobes drop for a cycle between accesses
	task automatic acc(input logic wr, input logic sup, input logic [3:0] a,
		input logic [31:0] d, input logic [31:0] e, input logic er);
		reg_wr_i = wr;
		reg_rd_i = !wr;
		reg_sup_i = sup;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(posedge core_clk_i);
		#1;
		cmp(32'({reg_ack_o, reg_err_o}), 32'({1'b1, er}));
		if (!wr) cmp(reg_rdata_o, e);
		reg_wr_i = 0;
		reg_rd_i = 0;
		@(posedge core_clk_i);
		#1;
	endtask
	task automatic w(input logic [3:0] a, input logic [31:0] d);
		acc(1, 1, a, d, 32'h0, 0);
	endtask
	task automatic r(input logic [3:0] a, input logic [31:0] e);
		acc(0, 1, a, 32'h0, e, 0);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			finish_test;
		end
	end
	// ==========================================================
	// Sequence
	initial begin
		repeat (2) @(posedge core_clk_i);
		#1;
		rst_i = 0;
		@(posedge core_clk_i);
		#1;
		for (int a = 0; a < 16; a++) r(4'(a), 32'h0);
		// Distinct word per level register catches a wrong word select
		for (int p = 8; p < 16; p++) w(4'(p), {8{4'(p)}});
		for (int p = 8; p < 16; p++) r(4'(p), {8{4'(p)}});
		for (int p = 8; p < 16; p++) w(4'(p), 32'h0);
		acc(1, 0, REG_ENA_LO, 32'hFFFF_FFFF, 32'h0, 1);
		w(REG_EN_NUM, 32'h5);
		r(REG_ENA_LO, 32'h20);
		acc(0, 0, REG_ENA_LO, 32'h0, 32'h0, 1);
		w(REG_EN_NUM, 32'h28);
		r(REG_ENA_HI, 32'h100);
		w(REG_DIS_NUM, 32'h5);
		r(REG_ENA_LO, 32'h0);
		w(REG_ENA_LO, 32'h18);
		w(REG_PRIO0, 32'h0002_2000);
		r(REG_PRIO0, 32'h0002_2000);
		src_i = 64'h0000_0100_0000_0018;
		chk_irq(0, 6'h0, 1, 6'h4, 4'h2);
		for (int l = 0; l < 16; l++) begin
			w(REG_PRIO0, {12'h0, 4'h2, 4'(l), 12'h0});
			chk_irq(0, 6'h0, 1, l > 2 ? 6'h3 : 6'h4, l > 2 ? 4'(l) : 4'h2);
		end
		w(REG_MASK, 32'hE);
		chk_irq(0, 6'h0, 1, 6'h3, 4'hF);
		w(REG_MASK, 32'hF);
		chk_irq(0, 6'h0, 0, 6'h0, 4'h0);
		w(REG_MASK, 32'h0);
		w(REG_TYPE_HI, 32'h100);
		w(REG_TYPE_LO, 32'h10);
		chk_irq(1, 6'h28, 1, 6'h3, 4'hF);
		r(REG_VECTOR, 32'hC028_0F03);
		w(REG_DIS_NUM, 32'h3);
		chk_irq(1, 6'h28, 0, 6'h0, 4'h0);
		cmp(32'(n_fast), 32'h1);
		// Mid-run reset with sources still high clears every setting
		rst_i = 1;
		repeat (2) @(posedge core_clk_i);
		#1;
		cmp(32'({fast_req_o, norm_req_o, fast_src_o, norm_src_o, norm_lvl_o, reg_ack_o,
			reg_err_o}), 32'h0);
		rst_i = 0;
		@(posedge core_clk_i);
		#1;
		r(REG_ENA_HI, 32'h0);
		r(REG_TYPE_HI, 32'h0);
		r(REG_PRIO0, 32'h0);
		r(REG_MASK, 32'h0);
		chk_irq(0, 6'h0, 0, 6'h0, 4'h0);
		src_i = 64'h0;
		chk_irq(0, 6'h0, 0, 6'h0, 4'h0);
		finish_test;
	end
endmodule
